//--- hdl/fstc_pkg.sv
// Package of offsets, field positions, reset values and sizes for the FIFO status and test control block.
package fstc_pkg;
   // ---------------------------------------------------------------------
   // Register offsets (byte addresses are four times the index).
   // ---------------------------------------------------------------------
   localparam logic [7:0] FSTC_IDX_PIN_TEST   = 8'h1a;  // Pin routing test register index.
   localparam logic [7:0] FSTC_IDX_MODE_TEST  = 8'h1b;  // Test mode control register index.
   localparam logic [7:0] FSTC_IDX_FIFO_LEVEL = 8'h1c;  // FIFO fill level register index.
   localparam logic [7:0] FSTC_IDX_TX_UPPER   = 8'h1d;  // Transmit count upper byte index.
   localparam logic [7:0] FSTC_IDX_TX_LOWER   = 8'h1e;  // Transmit count lower byte index.
   localparam logic [7:0] FSTC_IDX_FIFO_DATA  = 8'h1f;  // FIFO data window index.
   // ---------------------------------------------------------------------
   // Reset values.
   // ---------------------------------------------------------------------
   localparam logic [7:0] FSTC_RST_BYTE = 8'h00;         // Reset value of every register.
   // ---------------------------------------------------------------------
   // Field positions in the pin routing test register.
   // ---------------------------------------------------------------------
   localparam int FSTC_POS_SUBC_IN   = 7;  // Keying pin feeds the decoder.
   localparam int FSTC_POS_SUBC_OUT  = 6;  // Subcarrier driven on modulation pin.
   localparam int FSTC_POS_DIRECT    = 5;  // Modulation pin becomes an input.
   localparam int FSTC_POS_STAGE_SEL = 4;  // Amplifier stage selection.
   localparam int FSTC_POS_GAIN_PRB  = 0;  // Gain level probe on strength bits.
   // ---------------------------------------------------------------------
   // Field positions in the test mode control register.
   // ---------------------------------------------------------------------
   localparam int FSTC_POS_PROBE_HI  = 3;  // Pin probe high bit.
   localparam int FSTC_POS_PROBE_LO  = 2;  // Pin probe low bit.
   localparam int FSTC_POS_DEC_TEST  = 1;  // Decoder test bit.
   localparam int FSTC_POS_FAST_CLK  = 0;  // Encoder fast clock bit.
   localparam logic [7:0] FSTC_MODE_STICKY = 8'h0e;  // Bits cleared by the stop condition.
   // ---------------------------------------------------------------------
   // Transmit length layout and FIFO size.
   // ---------------------------------------------------------------------
   localparam int FSTC_POS_PARTIAL   = 0;   // Partial byte flag in the lower byte.
   localparam int FSTC_FIFO_DEPTH    = 128; // Bytes the FIFO holds.
endpackage

//--- hdl/fstc_mem.sv
// Byte memory that holds the FIFO contents, with registered read data.
`timescale 1ns/1ps
`default_nettype none
module fstc_mem #(
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   // Clock.
   input  wire logic          sys_clk,
   // Write port.
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // Read port.
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);
   // Storage array; no reset, contents are undefined until written.
   logic [7:0] mem_q [DEPTH];
   initial begin
      if (DEPTH != (1 << AW)) $error("fstc_mem: DEPTH must equal 2**AW");
   end
   // Write, and register the read word so read data comes from a flop.
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
   end
endmodule // fstc_mem
`default_nettype wire

//--- hdl/fstc_fifo.sv
// Byte FIFO with fill count and sticky overflow flag.
`timescale 1ns/1ps
`default_nettype none
module fstc_fifo
   import fstc_pkg::*;
#(
   parameter int DEPTH = FSTC_FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // Push side.
   input  wire logic       push,
   input  wire logic [7:0] push_data,
   // Pop side; data appears one cycle after pop.
   input  wire logic       pop,
   output logic      [7:0] pop_data,
   // Status.
   input  wire logic       clear,
   output logic [$clog2(DEPTH):0] count,
   output logic            overflow
);
   localparam int AW = $clog2(DEPTH);
   // Pointers, count and overflow.
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          ovf_q, ovf_d;
   logic          do_push, do_pop;
   // Next state: a push into a full FIFO is dropped and flags overflow.
   always_comb begin
      do_push = push && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
      do_pop  = pop && (cnt_q != '0);
      wp_d    = do_push ? wp_q + 1'b1 : wp_q;
      rp_d    = do_pop ? rp_q + 1'b1 : rp_q;
      cnt_d   = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      ovf_d   = ovf_q;
      if (clear) begin
         ovf_d = 1'b0;
         wp_d  = '0;
         rp_d  = '0;
         cnt_d = '0;
      end
      // A byte beyond capacity sets overflow, winning over clear.
      if (push && !do_push) begin
         ovf_d = 1'b1;
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         ovf_q <= ovf_d;
      end
   end
   assign count    = cnt_q;
   assign overflow = ovf_q;
   fstc_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
      .sys_clk (sys_clk),
      .wr_en   (do_push),
      .wr_addr (wp_q),
      .wr_data (push_data),
      .rd_addr (rp_q),
      .rd_data (pop_data)
   );
endmodule // fstc_fifo
`default_nettype wire

//--- hdl/fstc_regs.sv
// Register bank for pin routing test, test mode, FIFO status and transmit count.
// What this block does
// - Test registers clear on power-on reset, enable low.
// - Top pin bit routes keying pin into decoder.
// - Bit six drives subcarrier out modulation pin.
// - Bit five makes modulation pin input, resets receiver.
// - Bit four selects amplifier stage output.
// - Low pin bit shows gain level as strength.
// - Decoder or probe bits enter persistent test mode.
// - Stop condition clears decoder and probe bits.
// - Probe bits have no function beyond mode entry.
// - Low mode bit clocks encoder at fast rate.
// - Overflow flag sets beyond 128 presented bytes.
// - Low seven status bits give FIFO count.
// - Upper length byte holds count bits eleven-four.
// - Upper length byte clears at reset, frame end.
// - Lower length upper nibble holds count bits three-zero.
// - Partial bit count applies only when flag set.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fstc_regs
   import fstc_pkg::*;
#(
   parameter int FIFO_DEPTH = FSTC_FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Chip-level reset qualifiers.
   input  wire logic        por,
   input  wire logic        chip_en,
   // Wishbone classic slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Receive side bytes entering the FIFO.
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   // Frame and test events.
   input  wire logic        tx_frame_end,
   input  wire logic        stop_cond,
   // Pins: keying pin input, modulation pin three-signal form.
   input  wire logic        onoff_keying_pin_i,
   input  wire logic        keying_control_pin_i,
   output logic             keying_control_pin_o,
   output logic             keying_control_pin_oe,
   // Signals from the transceiver core.
   input  wire logic        core_tx_mod,
   input  wire logic        core_rx_subcarrier,
   input  wire logic        demod_digital,
   input  wire logic [2:0]  rssi_normal,
   input  wire logic [2:0]  agc_level,
   // Signals to the transceiver core.
   output logic             decoder_input,
   output logic             rx_reset,
   output logic             stage_select,
   output logic [2:0]       rssi_shown,
   output logic             test_mode,
   output logic             encoder_fast_clock,
   output logic             tx_modulation,
   output logic [11:0]      send_count,
   output logic [2:0]       partial_bits,
   output logic             partial_flag
);
   import fstc_pkg::*;

   // ---------------------------------------------------------------------
   // Elaboration checks.
   // ---------------------------------------------------------------------
   initial begin
      if (FIFO_DEPTH != 128) $error("fstc_regs: status layout serves 128 bytes only");
   end

   // ---------------------------------------------------------------------
   // Register state.
   // ---------------------------------------------------------------------
   logic [7:0]  pin_routing_test_q, pin_routing_test_d;   // Pin routing test.
   logic [7:0]  test_mode_control_q, test_mode_control_d; // Test mode control.
   logic [7:0]  tx_count_upper_q, tx_count_upper_d;       // Count bits 11..4.
   logic [7:0]  tx_count_lower_q, tx_count_lower_d;       // Count bits 3..0, partial.
   logic        test_mode_q, test_mode_d;                 // Test mode latch.
   logic        ack_q, ack_d;                             // Bus answer.
   logic        err_q, err_d;                             // Unmapped answer.
   logic        rd_pend_q, rd_pend_d;                     // FIFO data read in flight.
   logic [31:0] dat_q, dat_d;                             // Read data.
   logic [7:0]  fifo_count;                               // FIFO count.
   logic        fifo_ovf;                                 // FIFO overflow.
   logic [7:0]  fifo_rdata;                               // FIFO read word.
   logic        req, wr_lane0, known, fifo_pop, chip_clear;

   // Decode of the printed index from the byte address.
   function automatic logic is_idx(input logic [7:0] adr, input logic [7:0] idx);
      return adr[7:2] == idx[5:0] && adr[1:0] == 2'b00;
   endfunction

   // ---------------------------------------------------------------------
   // FIFO.
   // ---------------------------------------------------------------------
   fstc_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .push      (rx_byte_valid),
      .push_data (rx_byte),
      .pop       (fifo_pop),
      .pop_data  (fifo_rdata),
      .clear     (chip_clear),
      .count     (fifo_count),
      .overflow  (fifo_ovf)
   );

   // ---------------------------------------------------------------------
   // Bus decode and register next state.
   // ---------------------------------------------------------------------
   // Writes take effect on the acknowledging edge; each access is answered
   // one cycle after the request, or two for a FIFO data read.
   always_comb begin
      chip_clear = por && !chip_en;
      req      = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
      known    = is_idx(wb_adr_i, FSTC_IDX_PIN_TEST) || is_idx(wb_adr_i, FSTC_IDX_MODE_TEST)
              || is_idx(wb_adr_i, FSTC_IDX_FIFO_LEVEL) || is_idx(wb_adr_i, FSTC_IDX_TX_UPPER)
              || is_idx(wb_adr_i, FSTC_IDX_TX_LOWER) || is_idx(wb_adr_i, FSTC_IDX_FIFO_DATA);
      wr_lane0 = req && known && wb_we_i && wb_sel_i[0];
      fifo_pop = req && !rd_pend_q && !wb_we_i && is_idx(wb_adr_i, FSTC_IDX_FIFO_DATA);
      pin_routing_test_d  = pin_routing_test_q;
      test_mode_control_d = test_mode_control_q;
      tx_count_upper_d    = tx_count_upper_q;
      tx_count_lower_d    = tx_count_lower_q;
      test_mode_d         = test_mode_q;
      ack_d     = 1'b0;
      err_d     = 1'b0;
      rd_pend_d = 1'b0;
      dat_d     = dat_q;
      if (wr_lane0 && is_idx(wb_adr_i, FSTC_IDX_PIN_TEST)) begin
         pin_routing_test_d = wb_dat_i[7:0];
      end
      if (wr_lane0 && is_idx(wb_adr_i, FSTC_IDX_MODE_TEST)) begin
         test_mode_control_d = wb_dat_i[7:0];
      end
      if (wr_lane0 && is_idx(wb_adr_i, FSTC_IDX_TX_UPPER)) begin
         tx_count_upper_d = wb_dat_i[7:0];
      end
      if (wr_lane0 && is_idx(wb_adr_i, FSTC_IDX_TX_LOWER)) begin
         tx_count_lower_d = wb_dat_i[7:0];
      end
      // Status register takes no write; the decode above has no entry.
      // Any of the decoder or probe bits latches test mode until stop.
      if ((test_mode_control_d & FSTC_MODE_STICKY) != 8'h00) begin
         test_mode_d = 1'b1;
      end
      // Stop condition clears sticky bits and leaves test mode.
      if (stop_cond) begin
         test_mode_control_d = test_mode_control_d & ~FSTC_MODE_STICKY;
         test_mode_d         = 1'b0;
      end
      // Frame end clears both length bytes.
      if (tx_frame_end) begin
         tx_count_upper_d = FSTC_RST_BYTE;
         tx_count_lower_d = FSTC_RST_BYTE;
      end
      // Power-on reset with enable low clears all four registers, test mode and the FIFO.
      if (chip_clear) begin
         pin_routing_test_d  = FSTC_RST_BYTE;
         test_mode_control_d = FSTC_RST_BYTE;
         tx_count_upper_d    = FSTC_RST_BYTE;
         tx_count_lower_d    = FSTC_RST_BYTE;
         test_mode_d         = 1'b0;
      end
      // Answer and read data.
      if (rd_pend_q) begin
         ack_d = 1'b1;
         dat_d = {24'h00_0000, fifo_rdata};
      end else if (fifo_pop) begin
         rd_pend_d = 1'b1;
      end else if (req && !known) begin
         err_d = 1'b1;
         dat_d = 32'h0000_0000;
      end else if (req) begin
         ack_d = 1'b1;
         dat_d = 32'h0000_0000;
         if (is_idx(wb_adr_i, FSTC_IDX_PIN_TEST)) begin
            dat_d[7:0] = pin_routing_test_q;
         end else if (is_idx(wb_adr_i, FSTC_IDX_MODE_TEST)) begin
            dat_d[7:0] = test_mode_control_q;
         end else if (is_idx(wb_adr_i, FSTC_IDX_FIFO_LEVEL)) begin
            dat_d[7:0] = {fifo_ovf, fifo_count[6:0]};
         end else if (is_idx(wb_adr_i, FSTC_IDX_TX_UPPER)) begin
            dat_d[7:0] = tx_count_upper_q;
         end else if (is_idx(wb_adr_i, FSTC_IDX_TX_LOWER)) begin
            dat_d[7:0] = tx_count_lower_q;
         end
      end
   end

   // Register every piece of state.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_routing_test_q  <= FSTC_RST_BYTE;
         test_mode_control_q <= FSTC_RST_BYTE;
         tx_count_upper_q    <= FSTC_RST_BYTE;
         tx_count_lower_q    <= FSTC_RST_BYTE;
         test_mode_q         <= 1'b0;
         ack_q               <= 1'b0;
         err_q               <= 1'b0;
         rd_pend_q           <= 1'b0;
         dat_q               <= 32'h0000_0000;
      end else begin
         pin_routing_test_q  <= pin_routing_test_d;
         test_mode_control_q <= test_mode_control_d;
         tx_count_upper_q    <= tx_count_upper_d;
         tx_count_lower_q    <= tx_count_lower_d;
         test_mode_q         <= test_mode_d;
         ack_q               <= ack_d;
         err_q               <= err_d;
         rd_pend_q           <= rd_pend_d;
         dat_q               <= dat_d;
      end
   end

   // ---------------------------------------------------------------------
   // Pin routing and core controls.
   // ---------------------------------------------------------------------
   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   // Keying pin replaces the demodulator as decoder input.
   assign decoder_input = pin_routing_test_q[FSTC_POS_SUBC_IN] ? onoff_keying_pin_i
                                                               : demod_digital;
   // Direct keying turns the pin around; it wins over subcarrier output.
   assign keying_control_pin_oe = !pin_routing_test_q[FSTC_POS_DIRECT];
   // Subcarrier out replaces normal modulation on the pin.
   assign keying_control_pin_o  = pin_routing_test_q[FSTC_POS_SUBC_OUT] ? core_rx_subcarrier
                                                                         : core_tx_mod;
   assign rx_reset     = pin_routing_test_q[FSTC_POS_DIRECT];
   // Under direct keying the host level on the pin keys the transmitter;
   // otherwise the core's own modulation is used.
   assign tx_modulation = pin_routing_test_q[FSTC_POS_DIRECT] ? keying_control_pin_i
                                                               : core_tx_mod;
   assign stage_select = pin_routing_test_q[FSTC_POS_STAGE_SEL];
   assign rssi_shown   = pin_routing_test_q[FSTC_POS_GAIN_PRB] ? agc_level : rssi_normal;
   assign test_mode    = test_mode_q;
   assign encoder_fast_clock = test_mode_control_q[FSTC_POS_FAST_CLK];
   // Full 12-bit count from both length bytes.
   assign send_count   = {tx_count_upper_q, tx_count_lower_q[7:4]};
   assign partial_flag = tx_count_lower_q[FSTC_POS_PARTIAL];
   // Partial bit count is masked unless the flag is set.
   assign partial_bits = partial_flag ? tx_count_lower_q[3:1] : 3'b000;

   // ---------------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------------
   property p_chip_clear;
      @(posedge sys_clk) disable iff (!resetn)
      chip_clear |=> (pin_routing_test_q == 8'h00) && (test_mode_control_q == 8'h00);
   endproperty
   a_chip_clear: assert property (p_chip_clear) else $error("test regs not cleared");
   property p_dec_in;
      @(posedge sys_clk) disable iff (!resetn)
      pin_routing_test_q[7] |-> decoder_input == onoff_keying_pin_i;
   endproperty
   a_dec_in: assert property (p_dec_in) else $error("decoder input not keying pin");
   property p_direct;
      @(posedge sys_clk) disable iff (!resetn)
      pin_routing_test_q[5] |-> !keying_control_pin_oe && rx_reset;
   endproperty
   a_direct: assert property (p_direct) else $error("direct keying pin still driven");
   property p_rssi;
      @(posedge sys_clk) disable iff (!resetn)
      pin_routing_test_q[0] |-> rssi_shown == agc_level;
   endproperty
   a_rssi: assert property (p_rssi) else $error("gain level not shown");
   sequence s_enter;
      (test_mode_control_q[1] || test_mode_control_q[2] || test_mode_control_q[3]) && !stop_cond;
   endsequence
   property p_enter;
      @(posedge sys_clk) disable iff (!resetn)
      s_enter ##1 !stop_cond && !chip_clear |-> test_mode;
   endproperty
   a_enter: assert property (p_enter) else $error("test mode not entered");
   property p_stop;
      @(posedge sys_clk) disable iff (!resetn)
      stop_cond |=> !test_mode && (test_mode_control_q[3:1] == 3'b000);
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not clear test bits");
   property p_status;
      @(posedge sys_clk) disable iff (!resetn)
      ack_q && $past(is_idx(wb_adr_i, FSTC_IDX_FIFO_LEVEL)) && $past(!wb_we_i) && !$past(rd_pend_q)
         |-> wb_dat_o[7:0] == $past({fifo_ovf, fifo_count[6:0]});
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");
   property p_frame_end;
      @(posedge sys_clk) disable iff (!resetn)
      tx_frame_end |=> send_count == 12'h000;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("count not cleared at frame end");
   property p_partial;
      @(posedge sys_clk) disable iff (!resetn)
      !partial_flag |-> partial_bits == 3'b000;
   endproperty
   a_partial: assert property (p_partial) else $error("partial bits leak");
endmodule // fstc_regs
`default_nettype wire

//--- verif/fstc_pin_host.sv
// Host-side model of the modulation pin wire for the FIFO status and test control bench.
`timescale 1ns/1ps
`default_nettype none
module fstc_pin_host (
   // Device side of the pin.
   input  wire logic pin_o,
   input  wire logic pin_oe,
   // Host drive level, used only while the device has let go of the pin.
   input  wire logic host_level,
   // Resolved wire level fed back to the device.
   output logic      pin_i
);
   // The host drives keying only once the device has turned the pin into an input.
   assign pin_i = pin_oe ? pin_o : host_level;
endmodule // fstc_pin_host
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the FIFO status and test control register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fstc_pkg::*;
   typedef struct packed {logic err; logic chk; logic [7:0] d;} fstc_note_s;
   logic sys_clk = 0, resetn = 0, por = 0, chip_en = 1;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o;
   logic [7:0] wb_adr_i = 0, rx_byte = 0;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic rx_byte_valid = 0, tx_frame_end = 0, stop_cond = 0, host_lvl = 0;
   logic okp = 0, kp_i, kp_o, kp_oe, keying_control_pin = 0, subc = 0, demod = 0;
   logic [2:0] rssi_n = 3'h5, agc = 3'h2, rssi_s, pbits;
   logic dec_in, rx_rst, stage, tmode, fastc, pflag, txm;
   logic [11:0] scount;
   logic [7:0] hi, lo, fifo_b [0:4];
   fstc_note_s notes [$];
   int err_total = 0, compares = 0, seed = 71;
   always #2 sys_clk = ~sys_clk;
   fstc_regs dut_u (.sys_clk(sys_clk), .resetn(resetn), .por(por), .chip_en(chip_en),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
      .tx_frame_end(tx_frame_end), .stop_cond(stop_cond), .onoff_keying_pin_i(okp),
      .keying_control_pin_i(kp_i), .keying_control_pin_o(kp_o), .keying_control_pin_oe(kp_oe),
      .core_tx_mod(keying_control_pin), .core_rx_subcarrier(subc), .demod_digital(demod), .rssi_normal(rssi_n),
      .agc_level(agc), .decoder_input(dec_in), .rx_reset(rx_rst), .stage_select(stage),
      .rssi_shown(rssi_s), .test_mode(tmode), .encoder_fast_clock(fastc), .send_count(scount),
      .partial_bits(pbits), .partial_flag(pflag), .tx_modulation(txm));
   fstc_pin_host host_u (.pin_o(kp_o), .pin_oe(kp_oe), .host_level(host_lvl), .pin_i(kp_i));
   // Compare one value and count it; a mismatch is reported at once.
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Classic single Wishbone cycle; the expectation goes on the queue for the monitor.
   task wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
           input logic c, input logic er);
      int n;
      n = 0;
      notes.push_back('{er, c, e});
      @(posedge sys_clk);
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= {24'h0, d};
      do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1 && wb_err_o !== 1 && n < 40);
      if (n >= 40) begin
         chk("bus answer", 1, 0);
         print_verdict();
      end
      wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
      @(posedge sys_clk);
   endtask
   // Each answer takes the oldest note; data is checked on reads only.
   always @(posedge sys_clk) begin
      fstc_note_s nt;
      if (wb_ack_o === 1 || wb_err_o === 1) begin
         if (notes.size() == 0) begin
            chk("note queue", 1, 0);
         end else begin
            nt = notes.pop_front();
            chk("err", nt.err, wb_err_o);
            if (nt.chk) chk("rdata", {24'h0, nt.d}, wb_dat_o);
         end
      end
   end
   // Push bytes back to back with valid held high.
   task push(input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk); rx_byte_valid <= 1; rx_byte <= b + i[7:0];
      end
      @(posedge sys_clk); rx_byte_valid <= 0;
   endtask
   task pulse_stop();
      @(posedge sys_clk); stop_cond <= 1;
      @(posedge sys_clk); stop_cond <= 0;
   endtask
   task print_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin #200000; err_total++; print_verdict(); end
   initial begin
      hi = $random(seed); lo = $random(seed);
      repeat (5) @(posedge sys_clk);
      resetn <= 1;
      okp <= hi[0]; demod <= !hi[0]; subc <= lo[2]; keying_control_pin <= !lo[2]; host_lvl <= lo[2];
      foreach (fifo_b[i]) wb(0, 8'h68 + 8'(4 * i), 0, 0, 1, 0);
      wb(0, 8'h00, 0, 0, 0, 1);
      chk("dec_in", !hi[0], dec_in);
      chk("txmod", !lo[2], txm);
      wb(1, 8'h68, 8'h80, 0, 0, 0); chk("dec_in", okp, dec_in);
      wb(1, 8'h68, 8'h40, 0, 0, 0); chk("pin_o", {subc, 1'b1}, {kp_o, kp_oe});
      wb(1, 8'h68, 8'h60, 0, 0, 0); chk("pin_oe", 2'b01, {kp_oe, rx_rst});
      chk("txmod", lo[2], txm);
      wb(1, 8'h68, 8'h11, 0, 0, 0); chk("stage", {1'b1, agc}, {stage, rssi_s});
      wb(0, 8'h68, 0, 8'h11, 1, 0);
      wb(1, 8'h6c, 8'h0f, 0, 0, 0); chk("tmode", 2'b11, {tmode, fastc});
      pulse_stop();
      wb(0, 8'h6c, 0, 8'h01, 1, 0); chk("tmode", 0, tmode);
      wb(1, 8'h6c, 8'h04, 0, 0, 0); chk("probe", 2'b10, {tmode, fastc});
      pulse_stop();
      wb(1, 8'h74, hi, 0, 0, 0); wb(1, 8'h78, lo, 0, 0, 0);
      chk("count", {hi, lo[7:4]}, scount);
      chk("pflag", lo[0], pflag);
      chk("pbits", lo[0] ? lo[3:1] : 3'b000, pbits);
      @(posedge sys_clk); tx_frame_end <= 1;
      @(posedge sys_clk); tx_frame_end <= 0;
      wb(0, 8'h74, 0, 0, 1, 0); chk("count", 0, scount);
      wb_sel_i <= 4'h0; wb(1, 8'h74, 8'hff, 0, 0, 0);
      wb_sel_i <= 4'h1; wb(0, 8'h74, 0, 0, 1, 0);
      for (int i = 0; i < 5; i++) fifo_b[i] = 8'h3a + i[7:0];
      push(5, 8'h3a);
      wb(0, 8'h70, 0, 8'h05, 1, 0);
      wb(1, 8'h70, 8'hff, 0, 0, 0);
      wb(0, 8'h70, 0, 8'h05, 1, 0);
      foreach (fifo_b[i]) wb(0, 8'h7c, 0, fifo_b[i], 1, 0);
      wb(0, 8'h70, 0, 8'h00, 1, 0);
      push(129, 8'h00);
      wb(0, 8'h70, 0, 8'h80, 1, 0);
      wb(1, 8'h6c, 8'h01, 0, 0, 0); wb(1, 8'h74, 8'h5a, 0, 0, 0);
      @(posedge sys_clk); por <= 1; chip_en <= 0;
      @(posedge sys_clk); por <= 0; chip_en <= 1;
      wb(0, 8'h70, 0, 8'h00, 1, 0); wb(0, 8'h68, 0, 8'h00, 1, 0);
      wb(0, 8'h6c, 0, 8'h00, 1, 0); wb(0, 8'h74, 0, 8'h00, 1, 0);
      repeat (3) @(posedge sys_clk);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
